/* common/ie_codec_pkg.sv */
// shared constants, encodings and carriers for the reservation element codec
`default_nettype none
package ie_codec_pkg;
    // ****************************************
    // element identifiers and lengths
    // ****************************************
    localparam logic [7:0] EID_DRP = 8'h09;
    localparam logic [7:0] EID_AVAIL = 8'h08;
    localparam logic [7:0] EID_HIB_ANCHOR = 8'h11;
    localparam logic [7:0] EID_HIB_MODE = 8'h0A;
    localparam logic [7:0] HIB_MODE_LEN = 8'h02;
    localparam logic [7:0] DRP_LEN_BASE = 8'h04;
    localparam logic [5:0] AVAIL_MAX_OCTETS = 6'h20;
    localparam logic [5:0] ALLOC_MAX = 6'h3E;
    localparam int ZONES = 16;
    localparam int SLOTS_PER_ZONE = 16;
    localparam int ANCHORS = 2;

    // ****************************************
    // control word field positions
    // ****************************************
    localparam int CW_UNSAFE = 12;
    localparam int CW_TIE = 11;
    localparam int CW_OWNER = 10;
    localparam int CW_STATUS = 9;
    localparam int CW_REASON_LSB = 6;
    localparam int CW_STREAM_LSB = 3;
    localparam int CW_TYPE_LSB = 0;
    localparam int CW_RSVD_LSB = 13;

    // ****************************************
    // configuration register field positions
    // ****************************************
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_STREAM_LSB = 3;
    localparam int CFG_REASON_LSB = 6;
    localparam int CFG_OWNER = 9;
    localparam int CFG_ESTABLISHED = 10;
    localparam int CFG_CONFLICT = 11;
    localparam int CFG_MODIFIED = 12;
    localparam int CFG_NEW_REQUEST = 13;
    localparam int CFG_TIE_RD = 14;
    localparam int ANC_VALID = 24;
    localparam int ANC_CD_LSB = 16;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] A_CFG = 8'h00;
    localparam logic [7:0] A_PEER = 8'h04;
    localparam logic [7:0] A_DRP_HDR = 8'h08;
    localparam logic [7:0] A_ALLOC_PUSH = 8'h0C;
    localparam logic [7:0] A_ALLOC_CLR = 8'h10;
    localparam logic [7:0] A_HIB_MODE = 8'h14;
    localparam logic [7:0] A_HIB_HDR = 8'h18;
    localparam logic [7:0] A_ANCHOR0 = 8'h1C;
    localparam logic [7:0] A_ANCHOR1 = 8'h20;
    localparam logic [7:0] A_ANCHOR_HDR = 8'h24;
    localparam logic [7:0] A_AVAIL_LEN = 8'h28;
    localparam logic [7:0] A_AVAIL_HDR = 8'h2C;
    localparam logic [2:0] R_LIMIT = 3'h2;
    localparam logic [2:0] R_MASK = 3'h3;
    localparam logic [2:0] R_AVAIL = 3'h4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // ****************************************
    // encodings
    // ****************************************
    typedef enum logic [2:0] {
        RT_ALIEN_BP = 3'h0,
        RT_HARD = 3'h1,
        RT_SOFT = 3'h2,
        RT_PRIVATE = 3'h3,
        RT_PCA = 3'h4
    } rtype_e;

    typedef enum logic [2:0] {
        RC_ACCEPTED = 3'h0,
        RC_CONFLICT = 3'h1,
        RC_PENDING = 3'h2,
        RC_DENIED = 3'h3,
        RC_MODIFIED = 3'h4,
        RC_CANCELLED = 3'h5
    } reason_e;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } axil_rsp_s;

    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] rtype;
        logic [2:0] stream;
        logic [2:0] reason;
        logic owner;
        logic established;
        logic conflict;
        logic modified;
        logic tiebreak;
        logic [15:0] lfsr;
        logic [15:0] peer;
        logic [5:0] alloc_n;
        logic [255:0] alloc_mask;
        logic [255:0] limit;
        logic [255:0] avail;
        logic [5:0] avail_len;
        logic [7:0] hib_cd;
        logic [7:0] hib_dur;
        logic [1:0] anc_v;
        logic [1:0][7:0] anc_cd;
        logic [1:0][15:0] anc_addr;
    } state_s;

    localparam state_s STATE_RST = '{lfsr: LFSR_SEED, default: '0};
endpackage
`default_nettype wire

/* hw/reservation_ie_field_codec.sv */
// reservation, availability and hibernation element codec with an AXI4-Lite register slave
// What this block does
// - reservation element: id 9, length 4+4N, control, peer address, allocations
// - control word: rsvd 15..13, unsafe 12, tie 11, owner 10, status 9, reason, stream, type
// - type codes: 0 alien, 1 hard, 2 soft, 3 private, 4 contention; 5..7 reserved
// - stream, reason and peer address are reserved for alien and contention types
// - reason codes 0 accepted to 5 cancelled; 6 and 7 reserved; the code accepts a written 6 or 7 and sends it in the control word
// - owner negotiating or device maintaining an established reservation sends reason zero
// - reason modified when slots were removed or elements combined or split
// - status zero while negotiating or in conflict, one when granted or maintained
// - owner bit one for owner, zero for target, reserved for alien type
// - tie-breaker drawn randomly at request, then held for the reservation
// - owner sends target address, target sends owner address
// - unsafe set when any allocated slot exceeds reservation limits
// - superframe is 16 zones of 16 consecutive slots each
// - each element holds one or more four-octet allocation fields; the code sends none, length 4, after reset or an allocation clear
// - zone bitmap bit n marks zone n as holding reserved slots
// - slot bitmap bit m reserves slot m in every flagged zone
// - availability element: id 8, length 0 to 32 octets
// - availability bitmap: 256 bits, lsb is the first slot
// - availability bit one when the sender can accept a reservation there
// - hibernation anchor element: id 17, length 3N, address plus wakeup countdown
// - wakeup countdown counts superframes left; zero means active next superframe
// - hibernation mode element: id 10, length 2, countdown zero ends this superframe
// - hibernation duration gives superframes the sender intends to hibernate
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
module reservation_ie_field_codec (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic SF_TICK,
    input wire ie_codec_pkg::axil_req_s AXI_REQ,
    output var ie_codec_pkg::axil_rsp_s AXI_RSP
);
    import ie_codec_pkg::*;

    state_s s_r;
    state_s s_nxt;
    logic [15:0] ctrl_word;
    logic [15:0] peer_field;
    logic unsafe;
    logic typ_rsvd;
    logic [255:0] expand;
    logic [255:0] avail_trim;
    logic do_write;
    logic new_req;
    logic alloc_push;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [7:0] anc_len;

    // ****************************************
    // byte-lane merge for partial writes
    // ****************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // element field composition
    // ****************************************
    // alien and contention types carry no stream, reason or peer
    assign typ_rsvd = (s_r.rtype == RT_ALIEN_BP) || (s_r.rtype == RT_PCA);
    assign unsafe = |(s_r.alloc_mask & ~s_r.limit);

    // control word built from configuration; modified outranks the zero reason
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[CW_RSVD_LSB +: 3] = 3'h0;
        ctrl_word[CW_TYPE_LSB +: 3] = s_r.rtype;
        ctrl_word[CW_UNSAFE] = unsafe;
        ctrl_word[CW_TIE] = s_r.tiebreak;
        ctrl_word[CW_OWNER] = (s_r.rtype == RT_ALIEN_BP) ? 1'b0 : s_r.owner;
        ctrl_word[CW_STATUS] = s_r.established && !s_r.conflict;
        if (!typ_rsvd) begin
            ctrl_word[CW_STREAM_LSB +: 3] = s_r.stream;
            if (s_r.modified) begin
                ctrl_word[CW_REASON_LSB +: 3] = RC_MODIFIED;
            end else if (s_r.owner || s_r.established) begin
                ctrl_word[CW_REASON_LSB +: 3] = RC_ACCEPTED;
            end else begin
                ctrl_word[CW_REASON_LSB +: 3] = s_r.reason;
            end
        end
    end

    // software writes the other party's address for the role it plays
    assign peer_field = typ_rsvd ? 16'h0000 : s_r.peer;

    // zone by slot expansion of the word being written
    always_comb begin
        expand = '0;
        for (int z = 0; z < ZONES; z++) begin
            // slot 16z+m of the superframe sits in zone z at slot m
            if (s_r.w_data[z]) begin
                expand[SLOTS_PER_ZONE*z +: SLOTS_PER_ZONE] = s_r.w_data[31:16];
            end
        end
    end

    // octets beyond the advertised length read as zero
    always_comb begin
        avail_trim = '0;
        for (int o = 0; o < 32; o++) begin
            if (6'(o) < s_r.avail_len) begin
                avail_trim[8*o +: 8] = s_r.avail[8*o +: 8];
            end
        end
    end

    // anchor length is three octets per valid entry
    always_comb begin
        anc_len = 8'h00;
        for (int i = 0; i < ANCHORS; i++) begin
            if (s_r.anc_v[i]) begin
                anc_len = 8'(anc_len + 8'h03);
            end
        end
    end

    // ****************************************
    // bus handshakes
    // ****************************************
    // one write and one read in flight; address and data may arrive in either order
    always_comb begin
        AXI_RSP = '0;
        AXI_RSP.awready = !s_r.aw_got && !s_r.bvalid;
        AXI_RSP.wready = !s_r.w_got && !s_r.bvalid;
        AXI_RSP.bvalid = s_r.bvalid;
        AXI_RSP.bresp = s_r.bresp;
        AXI_RSP.arready = !s_r.rvalid;
        AXI_RSP.rvalid = s_r.rvalid;
        AXI_RSP.rresp = s_r.rresp;
        AXI_RSP.rdata = s_r.rdata;
    end

    assign do_write = s_r.aw_got && s_r.w_got;

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (AXI_REQ.araddr[7:5] == R_LIMIT) begin
            rd_word = s_r.limit[32*AXI_REQ.araddr[4:2] +: 32];
        end else if (AXI_REQ.araddr[7:5] == R_MASK) begin
            rd_word = s_r.alloc_mask[32*AXI_REQ.araddr[4:2] +: 32];
        end else if (AXI_REQ.araddr[7:5] == R_AVAIL) begin
            rd_word = avail_trim[32*AXI_REQ.araddr[4:2] +: 32];
        end else begin
            unique case (AXI_REQ.araddr)
                A_CFG: begin
                    rd_word[CFG_TYPE_LSB +: 3] = s_r.rtype;
                    rd_word[CFG_STREAM_LSB +: 3] = s_r.stream;
                    rd_word[CFG_REASON_LSB +: 3] = s_r.reason;
                    rd_word[CFG_OWNER] = s_r.owner;
                    rd_word[CFG_ESTABLISHED] = s_r.established;
                    rd_word[CFG_CONFLICT] = s_r.conflict;
                    rd_word[CFG_MODIFIED] = s_r.modified;
                    rd_word[CFG_TIE_RD] = s_r.tiebreak;
                end
                A_PEER: rd_word = {peer_field, s_r.peer};
                A_DRP_HDR: rd_word = {8'(DRP_LEN_BASE + {s_r.alloc_n, 2'b00}), EID_DRP,
                                      ctrl_word};
                A_ALLOC_PUSH: rd_word = {26'h0, s_r.alloc_n};
                A_HIB_MODE: rd_word = {16'h0000, s_r.hib_dur, s_r.hib_cd};
                A_HIB_HDR: rd_word = {s_r.hib_dur, s_r.hib_cd, HIB_MODE_LEN, EID_HIB_MODE};
                A_ANCHOR0: rd_word = {7'h00, s_r.anc_v[0], s_r.anc_cd[0], s_r.anc_addr[0]};
                A_ANCHOR1: rd_word = {7'h00, s_r.anc_v[1], s_r.anc_cd[1], s_r.anc_addr[1]};
                A_ANCHOR_HDR: rd_word = {16'h0000, anc_len, EID_HIB_ANCHOR};
                A_AVAIL_LEN: rd_word = {26'h0, s_r.avail_len};
                A_AVAIL_HDR: rd_word = {16'h0000, 2'b00, s_r.avail_len, EID_AVAIL};
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // ****************************************
    // next state
    // ****************************************
    // superframe countdowns run first so that a software write in the same cycle wins
    always_comb begin
        logic [31:0] w;
        logic wr_hit;
        w = 32'h0000_0000;
        wr_hit = 1'b1;
        new_req = 1'b0;
        alloc_push = 1'b0;
        s_nxt = s_r;
        s_nxt.lfsr = {s_r.lfsr[14:0], s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
        if (SF_TICK) begin
            if (s_r.hib_cd != 8'h00) begin
                s_nxt.hib_cd = 8'(s_r.hib_cd - 8'h01);
            end
            for (int i = 0; i < ANCHORS; i++) begin
                if (s_r.anc_v[i]) begin
                    if (s_r.anc_cd[i] == 8'h00) begin
                        s_nxt.anc_v[i] = 1'b0;
                    end else begin
                        s_nxt.anc_cd[i] = 8'(s_r.anc_cd[i] - 8'h01);
                    end
                end
            end
        end
        if (AXI_REQ.awvalid && !s_r.aw_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_addr = AXI_REQ.awaddr;
        end
        if (AXI_REQ.wvalid && !s_r.w_got && !s_r.bvalid) begin
            s_nxt.w_got = 1'b1;
            s_nxt.w_data = AXI_REQ.wdata;
            s_nxt.w_strb = AXI_REQ.wstrb;
        end
        if (s_r.bvalid && AXI_REQ.bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (do_write) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            if (s_r.aw_addr[7:5] == R_LIMIT) begin
                s_nxt.limit[32*s_r.aw_addr[4:2] +: 32] =
                    merge(s_r.limit[32*s_r.aw_addr[4:2] +: 32], s_r.w_data, s_r.w_strb);
            end else if (s_r.aw_addr[7:5] == R_AVAIL) begin
                s_nxt.avail[32*s_r.aw_addr[4:2] +: 32] =
                    merge(s_r.avail[32*s_r.aw_addr[4:2] +: 32], s_r.w_data, s_r.w_strb);
            end else if (s_r.aw_addr[7:5] == R_MASK) begin
                wr_hit = 1'b1;
            end else begin
                unique case (s_r.aw_addr)
                    A_CFG: begin
                        w = merge(32'h0000_0000, s_r.w_data, s_r.w_strb);
                        // reserved type codes are refused, the old type stays
                        if (w[CFG_TYPE_LSB +: 3] <= RT_PCA) begin
                            s_nxt.rtype = w[CFG_TYPE_LSB +: 3];
                        end
                        s_nxt.stream = w[CFG_STREAM_LSB +: 3];
                        s_nxt.reason = w[CFG_REASON_LSB +: 3];
                        s_nxt.owner = w[CFG_OWNER];
                        s_nxt.established = w[CFG_ESTABLISHED];
                        s_nxt.conflict = w[CFG_CONFLICT];
                        s_nxt.modified = w[CFG_MODIFIED];
                        new_req = w[CFG_NEW_REQUEST];
                        if (new_req) begin
                            s_nxt.tiebreak = s_r.lfsr[0];
                        end
                    end
                    A_PEER: begin
                        w = merge({16'h0000, s_r.peer}, s_r.w_data, s_r.w_strb);
                        s_nxt.peer = w[15:0];
                    end
                    A_ALLOC_PUSH: begin
                        // the length octet caps the field count
                        if (s_r.alloc_n < ALLOC_MAX) begin
                            alloc_push = 1'b1;
                            s_nxt.alloc_n = 6'(s_r.alloc_n + 6'h01);
                            s_nxt.alloc_mask = s_r.alloc_mask | expand;
                        end
                    end
                    A_ALLOC_CLR: begin
                        s_nxt.alloc_n = 6'h00;
                        s_nxt.alloc_mask = '0;
                    end
                    A_HIB_MODE: begin
                        w = merge({16'h0000, s_r.hib_dur, s_r.hib_cd}, s_r.w_data, s_r.w_strb);
                        s_nxt.hib_cd = w[7:0];
                        s_nxt.hib_dur = w[15:8];
                    end
                    A_ANCHOR0, A_ANCHOR1: begin
                        w = s_r.w_data;
                        s_nxt.anc_v[s_r.aw_addr[5]] = w[ANC_VALID];
                        s_nxt.anc_cd[s_r.aw_addr[5]] = w[ANC_CD_LSB +: 8];
                        s_nxt.anc_addr[s_r.aw_addr[5]] = w[15:0];
                    end
                    A_AVAIL_LEN: begin
                        w = s_r.w_data;
                        s_nxt.avail_len = (w[7:0] > 8'(AVAIL_MAX_OCTETS)) ? AVAIL_MAX_OCTETS :
                                          w[5:0];
                    end
                    A_DRP_HDR, A_HIB_HDR, A_ANCHOR_HDR, A_AVAIL_HDR: wr_hit = 1'b1;
                    default: wr_hit = 1'b0;
                endcase
            end
            s_nxt.bresp = wr_hit ? RESP_OKAY : RESP_DECERR;
        end
        if (s_r.rvalid && AXI_REQ.rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (AXI_REQ.arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_word;
            s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_DECERR;
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence write_taken_s;
        s_r.aw_got && s_r.w_got;
    endsequence

    sequence write_answer_s;
        s_r.bvalid ##0 !s_r.aw_got;
    endsequence

    sequence tie_draw_s;
        new_req;
    endsequence

    sequence read_taken_s;
        AXI_REQ.arvalid && !s_r.rvalid;
    endsequence

    property write_resp_p;
        write_taken_s |=> write_answer_s;
    endproperty

    property tie_hold_p;
        !new_req |=> $stable(s_r.tiebreak);
    endproperty

    // the draw takes the generator bit seen at the writing edge
    property tie_draw_p;
        tie_draw_s |=> s_r.tiebreak == $past(s_r.lfsr[0]);
    endproperty

    property read_resp_p;
        read_taken_s |=> s_r.rvalid;
    endproperty

    write_resp_a: assert property (write_resp_p) else $error("write answer missing");
    ctrl_layout_a: assert property (ctrl_word[15:13] == 3'h0 && ctrl_word[2:0] == s_r.rtype)
        else $error("control word layout wrong");
    type_legal_a: assert property (s_r.rtype <= RT_PCA) else $error("reserved type held");
    rsvd_fields_a: assert property (typ_rsvd |-> ctrl_word[8:3] == 6'h00 && peer_field == 16'h0)
        else $error("reserved fields not zero");
    reason_zero_a: assert property (!typ_rsvd && !s_r.modified && (s_r.owner || s_r.established)
        |-> ctrl_word[8:6] == RC_ACCEPTED) else $error("reason not zero");
    reason_mod_a: assert property (!typ_rsvd && s_r.modified |-> ctrl_word[8:6] == RC_MODIFIED)
        else $error("modified reason missing");
    status_bit_a: assert property (ctrl_word[9] == (s_r.established && !s_r.conflict))
        else $error("status bit wrong");
    owner_bit_a: assert property (s_r.rtype == RT_ALIEN_BP |-> !ctrl_word[10])
        else $error("owner bit set for alien type");
    tie_hold_a: assert property (tie_hold_p) else $error("tie-breaker changed");
    tie_draw_a: assert property (tie_draw_p) else $error("tie-breaker not drawn");
    read_resp_a: assert property (read_resp_p) else $error("read answer missing");
    avail_trim_a: assert property (s_r.avail_len == 6'h00 |-> avail_trim == '0)
        else $error("empty availability not zero");
    unsafe_flag_a: assert property (ctrl_word[12] == |(s_r.alloc_mask & ~s_r.limit))
        else $error("unsafe bit wrong");
    alloc_or_a: assert property (alloc_push |=> s_r.alloc_mask == ($past(s_r.alloc_mask)
        | $past(expand)) && s_r.alloc_n == 6'($past(s_r.alloc_n) + 6'h01))
        else $error("allocation not merged");
    avail_len_a: assert property (s_r.avail_len <= AVAIL_MAX_OCTETS)
        else $error("availability too long");
    wake_count_a: assert property (SF_TICK && s_r.anc_v[0] && s_r.anc_cd[0] != 8'h00 && !do_write
        |=> s_r.anc_cd[0] == 8'($past(s_r.anc_cd[0]) - 8'h01)) else $error("wakeup stuck");
    hib_count_a: assert property (SF_TICK && s_r.hib_cd != 8'h00 && !do_write
        |=> s_r.hib_cd == 8'($past(s_r.hib_cd) - 8'h01)) else $error("countdown stuck");
endmodule
`default_nettype wire

/* testbench/sf_timer_model.sv */
// superframe timer stand-in that issues end-of-superframe pulses
`default_nettype none
module sf_timer_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fire,
    output var logic tick
);
    timeunit 1ns;
    timeprecision 100ps;
    // registered one-cycle pulse per request; silent in reset so no stray countdown
    always_ff @(posedge clk) begin
        tick <= rst_n && fire;
    end
endmodule
`default_nettype wire

/* testbench/test_reservation_ie_field_codec.sv */
// self-checking bench for the reservation element codec
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_reservation_ie_field_codec import ie_codec_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0;
    logic rstn = 0;
    logic fire = 0;
    logic tick;
    axil_req_s r = '{bready: 1'b1, rready: 1'b1, default: '0};
    axil_rsp_s s;
    logic [34:0] expq[$];
    logic [34:0] e;
    logic [255:0] mask = '0;
    logic [13:0] c;
    logic [2:0] t;
    logic [31:0] d;
    logic tb = 1'b0;
    logic [1:0] bq[$];
    logic [1:0] b;
    int n_errors = 0;
    int checks = 0;
    always #12.5 clk = ~clk;
    reservation_ie_field_codec reservation_ie_field_codec_inst (.SYS_CLK(clk), .RSTN(rstn),
        .SF_TICK(tick), .AXI_REQ(r), .AXI_RSP(s));
    sf_timer_model sf_timer_model_inst (.clk(clk), .rst_n(rstn), .fire(fire), .tick(tick));
    // ****************************************
    // bus helpers
    // ****************************************
    function automatic logic [34:0] ok(input logic [31:0] v);
        return {1'b0, RESP_OKAY, v};
    endfunction
    // expected control word; modified outranks the zero reason
    function automatic logic [15:0] cw(input logic [13:0] f, input logic [2:0] ty, input logic u,
                                       input logic tb);
        logic [2:0] rc;
        logic [2:0] st;
        rc = f[12] ? 3'h4 : (f[9] || f[10]) ? 3'h0 : f[8:6];
        st = f[5:3];
        if (ty == 3'h0 || ty == 3'h4) begin
            rc = 3'h0;
            st = 3'h0;
        end
        return {3'h0, u, tb, f[9] && ty != 3'h0, f[10] && !f[11], rc, st, ty};
    endfunction
    // ready is sampled mid-cycle where it has settled, valid dropped after the taking edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] x = RESP_OKAY);
        logic pa, pw, ta, tw;
        pa = 1;
        pw = 1;
        bq.push_back(x);
        r.awvalid <= 1; r.awaddr <= a; r.wvalid <= 1; r.wdata <= v; r.wstrb <= 4'hF;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && s.awready;
            tw = pw && s.wready;
            @(posedge clk);
            if (ta) r.awvalid <= 0;
            if (tw) r.wvalid <= 0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge clk); while (!s.bvalid);
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [34:0] x);
        expq.push_back(x);
        r.arvalid <= 1;
        r.araddr <= a;
        do @(negedge clk); while (!s.arready);
        @(posedge clk);
        r.arvalid <= 0;
        do @(negedge clk); while (!s.rvalid);
        @(posedge clk);
    endtask
    task automatic pulse();
        fire <= 1;
        @(posedge clk);
        fire <= 0;
        repeat (2) @(posedge clk);
    endtask
    // read data compared against the oldest note; bit 34 means response only
    always @(negedge clk) begin
        if (s.rvalid) begin
            e = expq.pop_front();
            if (e[34]) `CHK(s.rresp, e[33:32])
            else `CHK({s.rresp, s.rdata}, e[33:0])
        end
        // write answers checked against their own queue
        if (s.bvalid) begin
            b = bq.pop_front();
            `CHK(s.bresp, b)
        end
    end
    task automatic tally_and_finish();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(45));
        repeat (20) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        rd(A_DRP_HDR, ok({8'h04, EID_DRP, 16'h0000}));
        t = 3'h0;
        for (int i = 0; i < 12; i++) begin
            c = (14'($urandom) & 14'h3FF8) | 14'(i % 8);
            if (c[2:0] < 3'h5) t = c[2:0];
            wr(A_CFG, 32'(c));
            // the drawn value is random; only its holding between draws is predictable
            rd(A_CFG, {1'b1, RESP_OKAY, 32'h0});
            if (!c[13]) `CHK(s.rdata[CFG_TIE_RD], tb)
            tb = s.rdata[CFG_TIE_RD];
            rd(A_DRP_HDR, ok({8'h04, EID_DRP, cw(c, t, 1'b0, tb)}));
            d = $urandom;
            wr(A_PEER, d);
            rd(A_PEER, ok({(t == 3'h0 || t == 3'h4) ? 16'h0 : d[15:0], d[15:0]}));
        end
        for (int j = 0; j < 2; j++) begin
            d = $urandom | 32'h00010001;
            wr(A_ALLOC_PUSH, d);
            for (int k = 0; k < 256; k++) if (d[k / 16] && d[16 + k % 16]) mask[k] = 1'b1;
        end
        rd(A_DRP_HDR, ok({8'h0C, EID_DRP, cw(c, t, 1'b1, tb)}));
        for (int i = 0; i < 8; i++) rd(8'h60 + 8'(4 * i), ok(mask[32 * i +: 32]));
        for (int i = 0; i < 8; i++) wr(8'h40 + 8'(4 * i), 32'hFFFFFFFF);
        rd(A_DRP_HDR, ok({8'h0C, EID_DRP, cw(c, t, 1'b0, tb)}));
        wr(A_ALLOC_CLR, 32'h0);
        rd(A_DRP_HDR, ok({8'h04, EID_DRP, cw(c, t, 1'b0, tb)}));
        d = $urandom;
        wr(8'h80, d);
        wr(A_AVAIL_LEN, 32'h2);
        rd(8'h80, ok({16'h0, d[15:0]}));
        rd(A_AVAIL_HDR, ok(32'h0208));
        wr(A_AVAIL_LEN, 32'h28);
        rd(A_AVAIL_HDR, ok(32'h2008));
        rd(8'h80, ok(d));
        wr(A_HIB_MODE, 32'h0501);
        wr(A_ANCHOR0, {8'h01, 8'h01, d[15:0]});
        rd(A_ANCHOR_HDR, ok(32'h0311));
        pulse();
        rd(A_HIB_HDR, ok(32'h0500020A));
        rd(A_ANCHOR0, ok({8'h01, 8'h00, d[15:0]}));
        pulse();
        rd(A_HIB_HDR, ok(32'h0500020A));
        rd(A_ANCHOR_HDR, ok(32'h0011));
        wr(8'h30, 32'h0, RESP_DECERR);
        rd(8'h30, {1'b1, RESP_DECERR, 32'h0});
        tally_and_finish();
    end
endmodule
`default_nettype wire
